// [rtl/uart_sdb_consts.svh]
// Offsets, field positions and reset values of the serial port.
// Assumes inclusion by bare name from rtl/.
`ifndef UART_SDB_CONSTS_SVH
`define UART_SDB_CONSTS_SVH
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h0c
`define OFS_DATA 8'h10
`define OFS_BAUD 8'h14
`define OFS_GTP 8'h18
`define CTL_PORT_EN 0
`define CTL_RX_EN 1
`define CTL_TX_EN 2
`define CTL_PAR_ODD 3
`define CTL_PAR_EN 4
`define CTL_WORD9 5
`define CTL_IDLE_IE 8
`define CTL_RXF_IE 9
`define CTL_TXE_IE 10
`define CTL_TXC_IE 11
`define CTL_IR_EN 12
`define CTL_IR_LP 13
`define CTL_SC_EN 14
`define ST_IDLE 6
`define ST_TXE 7
`define ST_TXC 8
`define ST_RXF 9
`define ST_ORE 13
`define STATUS_RESET 16'h0180
`endif

// [rtl/uart_sdb_pkg.sv]
// Types shared by the serial port design.
// Assumes the constants header is compiled alongside.
package uart_sdb_pkg;
   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;
   typedef struct packed {
      logic [15:0] ctl;
      logic [15:0] baud;
      logic [7:0] psc;
      logic txe, tx_complete_flag, rxf, ore, idle, idle_arm, sts_rd;
      logic [8:0] tx_buf, rx_buf;
      tx_state_t tx_st;
      logic [10:0] tx_sh;
      logic [3:0] tx_cnt;
      logic [15:0] tx_bc;
      logic [4:0] tx_fr;
      rx_state_t rx_st;
      logic [9:0] rx_sh;
      logic [3:0] rx_cnt;
      logic [15:0] rx_bc;
      logic [4:0] rx_fr;
      logic [3:0] idle_cnt;
      logic txd;
      logic [7:0] lp_cnt;
      logic lp_clk;
      logic [5:0] sc_cnt;
      logic sc_clk;
      logic irq;
      logic [31:0] rdata;
   } state_t;
endpackage

// [rtl/uart_sdb.sv]
// Serial port: status flags, data register, baud divider and prescaler.
// Assumes a synchronous register port and a synchronous receive pin.
// Function
// - Receive full sets on buffer load, interrupts
// - Receive full clears on zero write, read
// - Transmit complete is one after reset
// - Transmit complete sets at end, empty buffer
// - Transmit empty sets on reset, shift load
// - Transmit empty clears on data write
// - Idle flag after one idle frame
// - Idle clears on status then data read
// - Idle rearms only after new received word
// - Data register is nine bits wide
// - Parity replaces top transmitted bit
// - Baud writes ignored while port enabled
// - Baud counters stop while direction disabled
// - Divider: integer 15:4, fraction 3:0
// - Low-power clock divides by prescaler value
// - Card clock divides by twice prescaler bits 4:0
// - Receive-full enable also gates overrun
// - Low-power select gates prescaler clock
//
// Implementation choice: the plain strobed port.
`include "uart_sdb_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module uart_sdb
   import uart_sdb_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic rxd_i,
   output logic txd_o,
   output logic irq_o,
   output logic lp_clk_o,
   output logic card_clk_o
);

   state_t q, d;

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   // One fractional baud step: returns wrap flag in bit 21.
   function automatic logic [21:0] baud_step(input logic [15:0] bc,
      input logic [4:0] fr, input logic [15:0] div);
      logic [15:0] lim;
      logic [4:0] nf;
      lim = {4'h0, div[15:4]};
      nf = 5'h0;
      if (bc + 16'h0001 >= lim + {15'h0, fr[4]})
      begin
         // Carry the fraction so the mean period is div/16.
         nf = {1'b0, fr[3:0]} + {1'b0, div[3:0]};
         baud_step = {1'b1, 16'h0000, nf};
      end
      else
      begin
         baud_step = {1'b0, bc + 16'h0001, fr};
      end
   endfunction

   function automatic logic parity(input logic [8:0] v, input logic w9,
      input logic odd);
      parity = (w9 ? ^v[7:0] : ^v[6:0]) ^ odd;
   endfunction

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb
   begin
      logic [21:0] ts, rs;
      logic tx_tick, rx_tick, w9, rx_load, shift_load, frame_done;
      logic [8:0] wv;
      logic [3:0] nbits;
      ts = 22'h0;
      rs = 22'h0;
      tx_tick = 1'b0;
      rx_tick = 1'b0;
      rx_load = 1'b0;
      shift_load = 1'b0;
      frame_done = 1'b0;
      wv = 9'h0;
      d = q;
      w9 = q.ctl[`CTL_WORD9];
      nbits = w9 ? 4'ha : 4'h9;

      // Baud counters freeze while their direction is off.
      if (q.ctl[`CTL_TX_EN] && q.tx_st == TX_SHIFT)
      begin
         ts = baud_step(q.tx_bc, q.tx_fr, q.baud);
         tx_tick = ts[21];
         d.tx_bc = ts[20:5];
         d.tx_fr = ts[4:0];
      end
      if (q.ctl[`CTL_RX_EN])
      begin
         rs = baud_step(q.rx_bc, q.rx_fr, q.baud);
         rx_tick = rs[21];
         d.rx_bc = rs[20:5];
         d.rx_fr = rs[4:0];
      end

      // Transmitter.
      unique case (q.tx_st)
         TX_IDLE:
         begin
            d.txd = 1'b1;
            if (!q.txe && q.ctl[`CTL_TX_EN] && q.ctl[`CTL_PORT_EN])
            begin
               d.tx_sh = {1'b1, q.tx_buf, 1'b0};
               if (!w9)
               begin
                  d.tx_sh = {2'b11, q.tx_buf[7:0], 1'b0};
               end
               d.tx_st = TX_SHIFT;
               d.tx_cnt = 4'h0;
               d.tx_bc = 16'h0;
               d.tx_fr = 5'h0;
               d.txd = 1'b0;
               shift_load = 1'b1;
            end
         end
         TX_SHIFT:
         begin
            if (tx_tick)
            begin
               d.tx_sh = {1'b1, q.tx_sh[10:1]};
               d.txd = q.tx_sh[1];
               d.tx_cnt = q.tx_cnt + 4'h1;
               if (q.tx_cnt == nbits)
               begin
                  d.tx_st = TX_IDLE;
                  d.txd = 1'b1;
                  frame_done = 1'b1;
               end
            end
         end
         default:
         begin
            d.tx_st = TX_IDLE;
         end
      endcase

      // Receiver: samples once per bit after the start edge.
      unique case (q.rx_st)
         RX_IDLE:
         begin
            if (!rxd_i && q.ctl[`CTL_RX_EN])
            begin
               d.rx_st = RX_START;
               // Start half a bit in, so that every later tick lands mid-bit.
               d.rx_bc = {5'h0, q.baud[15:5]};
               d.rx_fr = 5'h0;
               d.rx_cnt = 4'h0;
            end
         end
         RX_START:
         begin
            if (rx_tick)
            begin
               d.rx_st = RX_DATA;
            end
         end
         RX_DATA:
         begin
            if (rx_tick)
            begin
               d.rx_sh = {rxd_i, q.rx_sh[9:1]};
               d.rx_cnt = q.rx_cnt + 4'h1;
               if (q.rx_cnt == nbits - 4'h1)
               begin
                  d.rx_st = RX_IDLE;
                  rx_load = 1'b1;
               end
            end
         end
         default:
         begin
            d.rx_st = RX_IDLE;
         end
      endcase
      if (!q.ctl[`CTL_RX_EN])
      begin
         d.rx_st = RX_IDLE;
      end

      // Idle line: a frame's worth of high bit times.
      if (q.rx_st != RX_IDLE || !rxd_i)
      begin
         d.idle_cnt = 4'h0;
      end
      else if (rx_tick && q.idle_arm)
      begin
         d.idle_cnt = q.idle_cnt + 4'h1;
      end

      // -----------------------------------------------------------
      // Register writes (flags are set afterwards, set wins)
      // -----------------------------------------------------------
      d.sts_rd = q.sts_rd;
      if (wr_i)
      begin
         unique case (addr_i)
            `OFS_CONTROL: d.ctl = wdata_i[15:0];
            `OFS_STATUS:
            begin
               if (!wdata_i[`ST_RXF])
               begin
                  d.rxf = 1'b0;
               end
               if (!wdata_i[`ST_TXC])
               begin
                  d.tx_complete_flag = 1'b0;
               end
            end
            `OFS_DATA:
            begin
               wv = wdata_i[8:0];
               if (q.ctl[`CTL_PAR_EN])
               begin
                  if (w9)
                  begin
                     wv[8] = parity(wv, 1'b1, q.ctl[`CTL_PAR_ODD]);
                  end
                  else
                  begin
                     wv[7] = parity(wv, 1'b0, q.ctl[`CTL_PAR_ODD]);
                  end
               end
               d.tx_buf = wv;
               d.txe = 1'b0;
            end
            `OFS_BAUD:
            begin
               if (!q.ctl[`CTL_PORT_EN])
               begin
                  d.baud = wdata_i[15:0];
               end
            end
            `OFS_GTP: d.psc = wdata_i[7:0];
            default: d.sts_rd = q.sts_rd;
         endcase
      end

      d.rdata = 32'h0;
      if (rd_i)
      begin
         unique case (addr_i)
            `OFS_CONTROL: d.rdata = {16'h0, q.ctl};
            `OFS_STATUS:
            begin
               d.rdata[`ST_IDLE] = q.idle;
               d.rdata[`ST_TXE] = q.txe;
               d.rdata[`ST_TXC] = q.tx_complete_flag;
               d.rdata[`ST_RXF] = q.rxf;
               d.rdata[`ST_ORE] = q.ore;
               d.sts_rd = 1'b1;
            end
            `OFS_DATA:
            begin
               d.rdata = {23'h0, q.rx_buf};
               d.rxf = 1'b0;
               if (q.sts_rd)
               begin
                  d.idle = 1'b0;
                  d.ore = 1'b0;
               end
               d.sts_rd = 1'b0;
            end
            `OFS_BAUD: d.rdata = {16'h0, q.baud};
            `OFS_GTP: d.rdata = {24'h0, q.psc};
            default: d.rdata = 32'h0;
         endcase
      end

      // -----------------------------------------------------------
      // Hardware flag sets
      // -----------------------------------------------------------
      if (shift_load)
      begin
         d.txe = 1'b1;
      end
      if (frame_done && (q.txe || shift_load))
      begin
         d.tx_complete_flag = 1'b1;
      end
      if (rx_load)
      begin
         d.rx_buf = w9 ? q.rx_sh[9:1] : {1'b0, q.rx_sh[9:2]};
         if (q.rxf)
         begin
            d.ore = 1'b1;
         end
         d.rxf = 1'b1;
         d.idle_arm = 1'b1;
      end
      if (q.idle_arm && q.idle_cnt == nbits + 4'h1)
      begin
         d.idle = 1'b1;
         d.idle_arm = 1'b0;
         d.idle_cnt = 4'h0;
      end

      d.irq = (q.rxf && q.ctl[`CTL_RXF_IE])
         || (q.ore && q.ctl[`CTL_RXF_IE])
         || (q.tx_complete_flag && q.ctl[`CTL_TXC_IE])
         || (q.txe && q.ctl[`CTL_TXE_IE])
         || (q.idle && q.ctl[`CTL_IDLE_IE]);

      // -----------------------------------------------------------
      // Prescaler clocks
      // -----------------------------------------------------------
      // A zero prescaler is reserved; it simply stops the clock.
      d.lp_clk = 1'b0;
      if (q.ctl[`CTL_IR_EN] && q.ctl[`CTL_IR_LP] && q.psc != 8'h00)
      begin
         // Divide by psc: high for one cycle every psc cycles.
         if (q.lp_cnt + 8'h01 >= q.psc)
         begin
            d.lp_cnt = 8'h00;
            d.lp_clk = 1'b1;
         end
         else
         begin
            d.lp_cnt = q.lp_cnt + 8'h01;
         end
      end
      else
      begin
         d.lp_cnt = 8'h00;
      end
      if (q.ctl[`CTL_SC_EN] && q.psc[4:0] != 5'h00)
      begin
         // Toggle every psc[4:0] cycles: divide by twice psc[4:0].
         if (q.sc_cnt + 6'h01 >= {1'b0, q.psc[4:0]})
         begin
            d.sc_cnt = 6'h00;
            d.sc_clk = ~q.sc_clk;
         end
         else
         begin
            d.sc_cnt = q.sc_cnt + 6'h01;
         end
      end
      else
      begin
         d.sc_cnt = 6'h00;
         d.sc_clk = 1'b0;
      end
   end

   // -------------------------------------------------------------
   // State register
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.txe <= 1'b1;
         q.tx_complete_flag <= 1'b1;
         q.txd <= 1'b1;
         q.idle_arm <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign rdata_o = q.rdata;
   assign txd_o = q.txd;
   assign irq_o = q.irq;
   assign lp_clk_o = q.lp_clk;
   assign card_clk_o = q.sc_clk;
endmodule
`default_nettype wire

// [bench/uart_sdb_checker.sv]
// Checker of register reads, interrupt masking and flag clearing.
// Assumes it is bound to uart_sdb and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module uart_sdb_checker (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic rxd_i,
   input wire logic txd_o,
   input wire logic irq_o,
   input wire logic lp_clk_o,
   input wire logic card_clk_o
);
   logic en_q;
   logic [15:0] baud_q;
   logic [7:0] psc_q;
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   // ----
   // Shadows of the port enable and divider registers, fed from write traffic only.
   // ----
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         en_q <= 1'b0;
         baud_q <= 16'h0;
         psc_q <= 8'h0;
      end
      else if (wr_i)
      begin
         if (addr_i == 8'h00)
            en_q <= wdata_i[0];
         if (addr_i == 8'h14 && !en_q)
            baud_q <= wdata_i[15:0];
         if (addr_i == 8'h18)
            psc_q <= wdata_i[7:0];
      end
   end
   sequence s_sts_rd;
      rd_i && addr_i == 8'h0c;
   endsequence
   sequence s_dat_rd;
      rd_i && addr_i == 8'h10;
   endsequence
   sequence s_dat_wr;
      wr_i && addr_i == 8'h10;
   endsequence
   a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data not zero outside a read");
   a_data_width: assert property ($past(rd_i && addr_i == 8'h10) |->
      rdata_o[31:9] == 23'h0) else $error("data read upper bits set");
   a_baud_lock: assert property ($past(rd_i && addr_i == 8'h14) |->
      rdata_o == {16'h0, baud_q}) else $error("baud divider value wrong");
   a_psc_value: assert property ($past(rd_i && addr_i == 8'h18) |->
      rdata_o == {24'h0, psc_q}) else $error("prescaler value wrong");
   a_unmapped_zero: assert property ($past(rd_i && !(addr_i inside
      {8'h00, 8'h0c, 8'h10, 8'h14, 8'h18})) |-> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_irq_mask: assert property (wr_i && addr_i == 8'h00 &&
      wdata_i[11:8] == 4'h0 |-> ##2 !irq_o) else $error("irq while masked");
   a_txe_clear: assert property (s_dat_wr ##1 s_sts_rd |=>
      !rdata_o[7]) else $error("empty flag seen after data write");
   a_read_clear: assert property (s_sts_rd ##1 s_dat_rd ##1 s_sts_rd
      |=> !rdata_o[9] && !rdata_o[6]) else $error("flags kept after read");
endmodule
bind uart_sdb uart_sdb_checker chk_i (.sys_clk_i(sys_clk_i),
   .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o),
   .irq_o(irq_o), .lp_clk_o(lp_clk_o), .card_clk_o(card_clk_o));
`default_nettype wire

// [bench/uart_sdb_node.sv]
// Remote serial node: sends frames on the receive line, captures sent ones.
// Assumes eight data bits, one stop bit and BIT clock cycles per bit.
`timescale 1ns/10ps
`default_nettype none
module uart_sdb_node #(
   parameter int BIT = 8
) (
   input wire logic sys_clk_i,
   input wire logic txd_i,
   output logic rxd_o,
   output logic [7:0] got_o
);
   initial rxd_o = 1'b1;
   initial got_o = 8'h0;
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int k = 0; k < 10; k++)
      begin
         @(posedge sys_clk_i);
         rxd_o <= f[k];
         repeat (BIT - 1) @(posedge sys_clk_i);
      end
   endtask
   // Sampling mid-bit keeps the capture clear of the line's edges.
   always @(negedge txd_i)
   begin
      repeat (BIT / 2) @(posedge sys_clk_i);
      for (int k = 0; k < 8; k++)
      begin
         repeat (BIT) @(posedge sys_clk_i);
         got_o[k] = txd_i;
      end
   end
endmodule
`default_nettype wire

// [bench/uart_sdb_test.sv]
// Self-checking bench of the serial port through its register port.
// Assumes the node model and the checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module uart_sdb_test;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr_i = 8'h0;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic rxd_i, txd_o, irq_o, lp_clk_o, card_clk_o;
   logic [7:0] got;
   int fail_count = 0;
   int compares = 0;
   int n_lp, n_sc, n_lo;
   always #2.5 sys_clk_i = ~sys_clk_i;
   uart_sdb dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .rxd_i(rxd_i), .txd_o(txd_o), .irq_o(irq_o), .lp_clk_o(lp_clk_o),
      .card_clk_o(card_clk_o));
   uart_sdb_node #(.BIT(8)) node (.sys_clk_i(sys_clk_i), .txd_i(txd_o),
      .rxd_o(rxd_i), .got_o(got));
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge sys_clk_i);
      wr_i <= w;
      rd_i <= !w;
      addr_i <= a;
      wdata_i <= d;
   endtask
   task automatic idle();
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
      idle();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      acc(1'b0, a, 32'h0);
      idle();
      chk(rdata_o, want);
   endtask
   task automatic watch(input int c);
      logic p;
      p = card_clk_o;
      n_lp = 0;
      n_sc = 0;
      n_lo = 0;
      repeat (c)
      begin
         @(posedge sys_clk_i);
         #1;
         n_lp += lp_clk_o;
         n_sc += (card_clk_o !== p);
         n_lo += !txd_o;
         p = card_clk_o;
      end
   endtask
   task automatic print_verdict();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge sys_clk_i);
      fail_count++;
      print_verdict();
   end
   initial
   begin
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd(8'h0c, 32'h0180);
      rd(8'h14, 32'h0);
      rd(8'h18, 32'h0);
      wr(8'h14, 32'h0080);
      rd(8'h14, 32'h0080);
      wr(8'h00, 32'h0007);
      wr(8'h14, 32'h0040);
      rd(8'h14, 32'h0080);
      rd(8'h20, 32'h0);
      wr(8'h0c, 32'h0);
      watch(120);
      rd(8'h0c, 32'h00c0);
      acc(1'b0, 8'h10, 32'h0);
      acc(1'b1, 8'h10, 32'h0055);
      acc(1'b0, 8'h0c, 32'h0);
      idle();
      chk(rdata_o & 32'h80, 32'h0);
      watch(120);
      chk({24'h0, got}, 32'h55);
      rd(8'h0c, 32'h0180);
      node.send(8'ha3);
      watch(120);
      rd(8'h0c, 32'h03c0);
      rd(8'h10, 32'h00a3);
      rd(8'h0c, 32'h0180);
      node.send(8'h5c);
      watch(120);
      wr(8'h0c, 32'h0100);
      rd(8'h0c, 32'h01c0);
      acc(1'b0, 8'h0c, 32'h0);
      acc(1'b0, 8'h10, 32'h0);
      acc(1'b0, 8'h0c, 32'h0);
      idle();
      chk(rdata_o, 32'h0180);
      wr(8'h00, 32'h0017);
      wr(8'h10, 32'h0007);
      watch(120);
      chk({24'h0, got}, 32'h87);
      wr(8'h00, 32'h001f);
      wr(8'h10, 32'h0007);
      watch(120);
      chk({24'h0, got}, 32'h07);
      wr(8'h00, 32'h0217);
      node.send(8'h11);
      watch(120);
      chk({31'h0, irq_o}, 32'h1);
      wr(8'h0c, 32'h0100);
      watch(2);
      chk({31'h0, irq_o}, 32'h0);
      wr(8'h00, 32'h0417);
      watch(2);
      chk({31'h0, irq_o}, 32'h1);
      node.send(8'h22);
      node.send(8'h33);
      rd(8'h0c, 32'h23c0);
      wr(8'h00, 32'h0217);
      wr(8'h0c, 32'h0100);
      watch(2);
      chk({31'h0, irq_o}, 32'h1);
      rd(8'h10, 32'h0033);
      watch(2);
      chk({31'h0, irq_o}, 32'h0);
      wr(8'h00, 32'h0023);
      node.send(8'ha5);
      watch(20);
      rd(8'h10, 32'h01a5);
      wr(8'h00, 32'h0003);
      wr(8'h10, 32'h0000);
      watch(120);
      chk(n_lo, 32'h0);
      wr(8'h18, 32'h0003);
      rd(8'h18, 32'h0003);
      wr(8'h00, 32'h3001);
      watch(60);
      chk(n_lp, 32'd20);
      wr(8'h00, 32'h1001);
      watch(60);
      chk(n_lp, 32'h0);
      wr(8'h18, 32'h0002);
      wr(8'h00, 32'h4001);
      watch(64);
      chk(n_sc, 32'd32);
      print_verdict();
   end
endmodule
`default_nettype wire
